//--- bench/fetc_link_partner.sv
// fetc_link_partner: far-end partner that decodes the transmit line and loops it back
`default_nettype none
module fetc_link_partner (
	input  wire logic                i_clk,
	input  wire fetc_pkg::fetc_mlt_s i_line,
	input  wire logic                i_sync,
	output var  fetc_pkg::fetc_mlt_s o_line,
	output logic                     o_grp_stb,
	output logic [4:0]               o_grp,
	output logic                     o_bad
);
	timeunit 1ns;
	timeprecision 1ps;
	fetc_pkg::fetc_mlt_s lvl_q;
	fetc_pkg::fetc_mlt_s last_pulse;
	logic [10:0]         lfsr;
	logic [9:0]          win;
	logic [2:0]          cnt;
	logic                in_frame;
	logic                kq;
	logic                tail;
	logic                c;
	logic                k;

	initial
	begin
		o_line = '0;
		o_grp_stb = 1'b0;
		o_grp = '0;
		o_bad = 1'b0;
		lvl_q = '0;
		last_pulse = '0;
		lfsr = '1;
		win = '0;
		cnt = '0;
		in_frame = 1'b0;
		kq = 1'b0;
		tail = 1'b0;
	end

	always @(posedge i_clk)
	begin
		// echo keeps the design's own line as the receive stimulus
		o_line <= i_line;
		o_grp_stb <= 1'b0;
		c = (i_line != lvl_q);
		if (i_line.pos & i_line.neg)
			o_bad <= 1'b1;
		if (i_line != '0 && c)
		begin
			if (i_line == last_pulse)
				o_bad <= 1'b1;
			last_pulse = i_line;
		end
		lvl_q = i_line;
		k = lfsr[10] ^ lfsr[8];
		// while syncing the line is assumed to carry idle, so the key is the inverted bit
		if (i_sync)
			k = ~c;
		lfsr = {lfsr[9:0], k};
		win = {win[8:0], c ^ k};
		if (in_frame)
		begin
			cnt = cnt + 3'h1;
			if (kq)
			begin
				o_grp_stb <= 1'b1;
				o_grp <= win[5:1];
				kq = 1'b0;
			end
			if (cnt == 3'h5)
			begin
				cnt = '0;
				o_grp_stb <= 1'b1;
				o_grp <= win[4:0];
				if (tail)
					in_frame = 1'b0;
				tail = (win[4:0] == 5'h07);
			end
		end
		else if (!i_sync && win == 10'h311)
		begin
			in_frame = 1'b1;
			cnt = '0;
			kq = 1'b1;
			tail = 1'b0;
			o_grp_stb <= 1'b1;
			o_grp <= win[9:5];
		end
	end
endmodule : fetc_link_partner
`default_nettype wire

//--- bench/test_fetc_top.sv
// test_fetc_top: self-checking bench, coding path looped back through the link partner
`default_nettype none
module test_fetc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         LOCK_N = 12;
	localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
	logic                  core_clk;
	logic                  nrst;
	fetc_pkg::fetc_txmii_s tx_mii;
	logic                  tx_bypass;
	logic [4:0]            tx_sym;
	logic                  tx_stb;
	fetc_pkg::fetc_mlt_s   tx_line;
	fetc_pkg::fetc_mlt_s   rx_line;
	logic                  sig_det;
	logic                  rx_lock;
	fetc_pkg::fetc_rxmii_s rx_mii;
	logic                  sync;
	logic                  grp_stb;
	logic [4:0]            grp;
	logic                  bad;
	int                    miscompares = 0;
	int                    tests_run = 0;
	logic [4:0]            grp_q [$];
	logic [5:0]            nib_q [$];

	fetc_top #(.LOCK_BITS(LOCK_N)) fetc_top_i (.i_core_clk(core_clk), .i_nrst(nrst), .i_tx_mii(tx_mii),
		.i_tx_bypass(tx_bypass), .i_tx_sym(tx_sym), .o_tx_stb(tx_stb), .o_tx_line(tx_line),
		.i_rx_line(rx_line), .i_sig_det(sig_det), .o_rx_lock(rx_lock), .o_rx_mii(rx_mii));
	fetc_link_partner fetc_link_partner_i (.i_clk(core_clk), .i_line(tx_line), .i_sync(sync),
		.o_line(rx_line), .o_grp_stb(grp_stb), .o_grp(grp), .o_bad(bad));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		if (grp_stb)
			grp_q.push_back(grp);
		if (rx_mii.stb)
			nib_q.push_back({rx_mii.dv, rx_mii.er, rx_mii.d});
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done

	// bounded wait for the transmit take strobe
	task automatic wait_stb;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (tx_stb !== 1'b1 && n < 20);
		chk(16'(tx_stb), 16'h1);
	endtask : wait_stb

	task automatic wait_lock;
		int n;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rx_lock !== 1'b1 && n < 400);
		chk(16'(rx_lock), 16'h1);
	endtask : wait_lock

	// line groups seen by the partner and nibbles handed to the mac
	task automatic check_frame(input logic [4:0] eg [$], input logic [5:0] en [$]);
		repeat (60) @(posedge core_clk);
		chk(16'(grp_q.size()), 16'(eg.size()));
		foreach (eg[i]) chk(16'(grp_q[i]), 16'(eg[i]));
		chk(16'(nib_q.size()), 16'(en.size()));
		foreach (en[i]) chk(16'(nib_q[i]), 16'(en[i]));
		chk(16'(rx_mii.dv), 16'h0);
		grp_q.delete();
		nib_q.delete();
	endtask : check_frame

	task automatic t_frame;
		logic [4:0] eg [$];
		logic [5:0] en [$];
		eg = '{5'h18, 5'h11};
		en = '{6'h25, 6'h25};
		tx_mii <= {1'b1, 4'h5};
		wait_stb;
		wait_stb;
		for (int i = 0; i < 16; i++)
		begin
			tx_mii.d <= 4'(i);
			wait_stb;
			eg.push_back(CODE[i]);
			en.push_back({2'b10, 4'(i)});
		end
		tx_mii.en <= 1'b0;
		eg.push_back(5'h0d);
		eg.push_back(5'h07);
		eg.push_back(5'h1f);
		check_frame(eg, en);
	endtask : t_frame

	// frame with no data nibbles: enable drops right after K, so T follows K
	task automatic t_short;
		logic [4:0] eg [$];
		logic [5:0] en [$];
		eg = '{5'h18, 5'h11, 5'h0d, 5'h07, 5'h1f};
		en = '{6'h25, 6'h25};
		tx_mii <= {1'b1, 4'h5};
		wait_stb;
		wait_stb;
		tx_mii.en <= 1'b0;
		check_frame(eg, en);
	endtask : t_short

	// pre-coded frame with one error or invalid group in its middle
	task automatic t_bypass(input logic [4:0] badg);
		logic [4:0] sq [$];
		logic [5:0] en [$];
		sq = '{5'h18, 5'h11, 5'h1e, badg, 5'h09, 5'h0d, 5'h07, 5'h1f};
		en = '{6'h25, 6'h25, 6'h20, 6'h30, 6'h21};
		tx_bypass <= 1'b1;
		foreach (sq[i])
		begin
			tx_sym <= sq[i];
			wait_stb;
		end
		tx_bypass <= 1'b0;
		check_frame(sq, en);
	endtask : t_bypass

	task automatic t_sigloss;
		sig_det <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk(16'(rx_lock), 16'h0);
		sig_det <= 1'b1;
		wait_lock;
		repeat (10) @(posedge core_clk);
	endtask : t_sigloss

	initial
	begin
		tx_mii = '0;
		tx_bypass = 1'b0;
		tx_sym = '0;
		sig_det = 1'b1;
		sync = 1'b1;
		nrst = 1'b0;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge core_clk);
		wait_lock;
		repeat (20) @(posedge core_clk);
		sync <= 1'b0;
		t_frame;
		t_short;
		t_bypass(5'h04);
		t_bypass(5'h00);
		t_bypass(5'h01);
		t_bypass(5'h19);
		t_sigloss;
		t_frame;
		chk(16'(bad), 16'h0);
		test_done;
	end

	// the whole run needs about a thousand cycles
	initial
	begin
		#200_000;
		miscompares++;
		test_done;
	end
endmodule : test_fetc_top
`default_nettype wire

//--- design/fetc_pkg.sv
// fetc_pkg: code groups, scrambler taps, states and carrier types of the coding path
`default_nettype none
package fetc_pkg;
	localparam int GRP_W        = 5;
	localparam int LFSR_W       = 11;
	localparam int TAP_HI       = 10;
	localparam int TAP_LO       = 8;
	localparam int RX_LOCK_BITS = 30;
	localparam logic [2:0]  GRP_LAST  = 3'h4;
	localparam logic [10:0] LFSR_SEED = 11'h7ff;
	localparam logic [4:0]  CG_IDLE   = 5'h1f;
	localparam logic [4:0]  CG_J      = 5'h18;
	localparam logic [4:0]  CG_K      = 5'h11;
	localparam logic [4:0]  CG_T      = 5'h0d;
	localparam logic [4:0]  CG_R      = 5'h07;
	localparam logic [4:0]  CG_H      = 5'h04;
	localparam logic [9:0]  CG_JK     = 10'h311;
	localparam logic [3:0]  PRE_NIB   = 4'h5;
	localparam logic [1:0]  MLT_POS   = 2'h1;
	localparam logic [1:0]  MLT_NEG   = 2'h3;
	localparam logic [4:0]  CG_DATA [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

	typedef enum logic [5:0] {TX_IDLE = 6'h01, TX_J = 6'h02, TX_K = 6'h04,
		TX_DATA = 6'h08, TX_T = 6'h10, TX_R = 6'h20} fetc_tx_e;
	typedef enum logic [2:0] {RX_HUNT = 3'h1, RX_FRAME = 3'h2, RX_ENDR = 3'h4} fetc_rx_e;

	typedef struct packed {logic en; logic [3:0] d;} fetc_txmii_s;
	typedef struct packed {logic dv; logic er; logic stb; logic [3:0] d;} fetc_rxmii_s;
	typedef struct packed {logic pos; logic neg;} fetc_mlt_s;

	typedef struct packed {
		fetc_tx_e     tx_st;
		logic [2:0]   tx_cnt;
		logic [4:0]   tx_sh;
		logic [10:0]  tx_lfsr;
		logic         tx_stb;
		logic         tx_nrzi;
		logic [1:0]   tx_ph;
		fetc_mlt_s    tx_line;
		fetc_mlt_s    rx_lvl;
		logic         rx_nrzi;
		logic         rx_nrzi_q;
		logic [10:0]  rx_lfsr;
		logic [5:0]   rx_mcnt;
		logic         rx_lock;
		logic [9:0]   rx_win;
		fetc_rx_e     rx_st;
		logic [2:0]   rx_cnt;
		logic         rx_pre2;
		fetc_rxmii_s  rx_mii;
	} fetc_st_s;

	// five key bits, first one for the group msb, plus the advanced register
	function automatic logic [15:0] fetc_scr5(input logic [10:0] seed);
		logic [10:0] s;
		logic [4:0]  k;
		s = seed;
		k = '0;
		for (int i = 4; i >= 0; i--)
		begin
			k[i] = s[TAP_HI] ^ s[TAP_LO];
			s = {s[9:0], k[i]};
		end
		return {k, s};
	endfunction : fetc_scr5

	// msb set when the group is one of the sixteen data groups
	function automatic logic [4:0] fetc_dec5(input logic [4:0] grp);
		logic [4:0] r;
		r = '0;
		for (int i = 0; i < 16; i++)
		begin
			if (CG_DATA[i] == grp)
				r = {1'b1, 4'(i)};
		end
		return r;
	endfunction : fetc_dec5
endpackage : fetc_pkg
`default_nettype wire

//--- design/fetc_top.sv
// fetc_top: 100 Mb/s transmit and receive coding path, one line symbol per core clock
//
// How it works
// - each data nibble goes out as its fixed five bit group from the data table.
// - frame start sends J then K in place of the first two preamble nibbles.
// - transmit enable falling ends the frame with T then R.
// - idle groups are sent whenever no frame is running, including after R.
// - bypass input sends the raw five bit symbol instead of the encoded nibble.
// - the key stream is xored onto each five bit group before serialising.
// - each scrambled group is shifted out msb first, one bit per clock.
// - serial bits are nrzi coded, a one toggles the level.
// - every nrzi transition steps the three level phase, so pulses alternate sign.
// - receive path turns the line bit stream into nibbles with a strobe.
// - three level input is turned back into an nrzi stream.
// - descrambler locks to idle on the line; clock is the core clock itself.
// - nrzi to nrz, a transition gives one, no transition gives zero.
// - the received bits are descrambled with the same key stream.
// - a J K pair in the window fixes the group boundary for the frame.
// - each aligned group is looked up in the same data table.
// - the J K pair is replaced by two preamble nibbles of 0101.
// - the T R pair ends the frame and yields no nibbles.
// - H and the invalid groups have no nibble value.
`default_nettype none
module fetc_top #(
	parameter int LOCK_BITS = fetc_pkg::RX_LOCK_BITS
) (
	input  wire logic                  i_core_clk,
	input  wire logic                  i_nrst,
	input  wire fetc_pkg::fetc_txmii_s i_tx_mii,
	input  wire logic                  i_tx_bypass,
	input  wire logic [4:0]            i_tx_sym,
	output logic                       o_tx_stb,
	output var  fetc_pkg::fetc_mlt_s   o_tx_line,
	input  wire fetc_pkg::fetc_mlt_s   i_rx_line,
	input  wire logic                  i_sig_det,
	output logic                       o_rx_lock,
	output var  fetc_pkg::fetc_rxmii_s o_rx_mii
);
	// the match counter is six bits and must outlast the register length
	if (LOCK_BITS < 12 || LOCK_BITS > 63)
	begin : g_chk
		$error("fetc_top: LOCK_BITS out of range");
	end

	logic [1:0]        rst_sync_ff;
	logic              rst_n;
	fetc_pkg::fetc_st_s s_ff;
	fetc_pkg::fetc_st_s nxt_s;
	logic [15:0]       tx_scr;
	logic [4:0]        tx_key;
	logic              tx_load;
	logic [4:0]        tx_grp;
	logic              rx_b;
	logic              rx_k;
	logic              rx_d;
	logic              rx_go;
	logic [4:0]        rx_grp;
	logic [4:0]        rx_dec;

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end
	assign rst_n = rst_sync_ff[1];

	assign tx_scr  = fetc_pkg::fetc_scr5(s_ff.tx_lfsr);
	assign tx_key  = tx_scr[15:11];
	assign tx_load = (s_ff.tx_cnt == fetc_pkg::GRP_LAST);

	always_comb
	begin
		nxt_s  = s_ff;
		tx_grp = fetc_pkg::CG_IDLE;
		rx_b   = s_ff.rx_nrzi ^ s_ff.rx_nrzi_q;
		rx_k   = s_ff.rx_lfsr[fetc_pkg::TAP_HI] ^ s_ff.rx_lfsr[fetc_pkg::TAP_LO];
		rx_d   = rx_b ^ rx_k;
		rx_go  = s_ff.rx_lock & i_sig_det;
		// transmit: group load every fifth clock, bits shift out between loads
		nxt_s.tx_stb = 1'b0;
		nxt_s.tx_sh  = {s_ff.tx_sh[3:0], 1'b0};
		nxt_s.tx_cnt = s_ff.tx_cnt + 3'h1;
		if (tx_load)
		begin
			nxt_s.tx_cnt = 3'h0;
			if (i_tx_bypass)
			begin
				tx_grp       = i_tx_sym;
				nxt_s.tx_st  = fetc_pkg::TX_IDLE;
				nxt_s.tx_stb = 1'b1;
			end
			else
			begin
				unique case (s_ff.tx_st)
					fetc_pkg::TX_IDLE:
					begin
						if (i_tx_mii.en)
						begin
							tx_grp       = fetc_pkg::CG_J;
							nxt_s.tx_st  = fetc_pkg::TX_J;
							nxt_s.tx_stb = 1'b1;
						end
					end
					fetc_pkg::TX_J:
					begin
						tx_grp       = fetc_pkg::CG_K;
						nxt_s.tx_st  = fetc_pkg::TX_K;
						nxt_s.tx_stb = 1'b1;
					end
					fetc_pkg::TX_K, fetc_pkg::TX_DATA:
					begin
						if (i_tx_mii.en)
						begin
							tx_grp       = fetc_pkg::CG_DATA[i_tx_mii.d];
							nxt_s.tx_st  = fetc_pkg::TX_DATA;
							nxt_s.tx_stb = 1'b1;
						end
						else
						begin
							tx_grp      = fetc_pkg::CG_T;
							nxt_s.tx_st = fetc_pkg::TX_T;
						end
					end
					fetc_pkg::TX_T:
					begin
						tx_grp      = fetc_pkg::CG_R;
						nxt_s.tx_st = fetc_pkg::TX_R;
					end
					fetc_pkg::TX_R:
						// at least one idle before the next J so the far end sees a gap
						nxt_s.tx_st = fetc_pkg::TX_IDLE;
					default:
						nxt_s.tx_st = fetc_pkg::TX_IDLE;
				endcase
			end
			nxt_s.tx_sh   = tx_grp ^ tx_key;
			nxt_s.tx_lfsr = tx_scr[10:0];
		end
		nxt_s.tx_nrzi = s_ff.tx_nrzi ^ s_ff.tx_sh[4];
		if (nxt_s.tx_nrzi != s_ff.tx_nrzi)
			nxt_s.tx_ph = s_ff.tx_ph + 2'h1;
		nxt_s.tx_line.pos = (nxt_s.tx_ph == fetc_pkg::MLT_POS);
		nxt_s.tx_line.neg = (nxt_s.tx_ph == fetc_pkg::MLT_NEG);
		// receive: any level change on the three level input is an nrzi toggle
		nxt_s.rx_lvl    = i_rx_line;
		nxt_s.rx_nrzi   = s_ff.rx_nrzi ^ (i_rx_line != s_ff.rx_lvl);
		nxt_s.rx_nrzi_q = s_ff.rx_nrzi;
		nxt_s.rx_mii.stb = 1'b0;
		if (!i_sig_det)
		begin
			nxt_s.rx_lock = 1'b0;
			nxt_s.rx_mcnt = 6'h00;
		end
		else if (!s_ff.rx_lock)
		begin
			// idle is all ones, so the inverted line bit is the key while hunting
			nxt_s.rx_lfsr = {s_ff.rx_lfsr[9:0], ~rx_b};
			if (rx_k == ~rx_b)
			begin
				nxt_s.rx_mcnt = s_ff.rx_mcnt + 6'h01;
				if (s_ff.rx_mcnt == 6'(LOCK_BITS - 1))
					nxt_s.rx_lock = 1'b1;
			end
			else
				nxt_s.rx_mcnt = 6'h00;
		end
		else
		begin
			nxt_s.rx_lfsr = {s_ff.rx_lfsr[9:0], rx_k};
			nxt_s.rx_win  = {s_ff.rx_win[8:0], rx_d};
		end
		rx_grp = nxt_s.rx_win[4:0];
		rx_dec = fetc_pkg::fetc_dec5(rx_grp);
		unique case (s_ff.rx_st)
			fetc_pkg::RX_HUNT:
			begin
				if (nxt_s.rx_win == fetc_pkg::CG_JK)
				begin
					nxt_s.rx_st      = fetc_pkg::RX_FRAME;
					nxt_s.rx_cnt     = 3'h0;
					nxt_s.rx_pre2    = 1'b1;
					nxt_s.rx_mii.dv  = 1'b1;
					nxt_s.rx_mii.er  = 1'b0;
					nxt_s.rx_mii.stb = 1'b1;
					nxt_s.rx_mii.d   = fetc_pkg::PRE_NIB;
				end
			end
			fetc_pkg::RX_FRAME:
			begin
				nxt_s.rx_cnt  = s_ff.rx_cnt + 3'h1;
				nxt_s.rx_pre2 = 1'b0;
				if (s_ff.rx_pre2)
				begin
					nxt_s.rx_mii.stb = 1'b1;
					nxt_s.rx_mii.d   = fetc_pkg::PRE_NIB;
				end
				if (s_ff.rx_cnt == fetc_pkg::GRP_LAST)
				begin
					nxt_s.rx_cnt = 3'h0;
					if (rx_grp == fetc_pkg::CG_T)
					begin
						nxt_s.rx_st     = fetc_pkg::RX_ENDR;
						nxt_s.rx_mii.dv = 1'b0;
						nxt_s.rx_mii.er = 1'b0;
					end
					else if (rx_grp == fetc_pkg::CG_IDLE)
					begin
						// frame cut short without T R: close it quietly
						nxt_s.rx_st     = fetc_pkg::RX_HUNT;
						nxt_s.rx_mii.dv = 1'b0;
						nxt_s.rx_mii.er = 1'b0;
					end
					else
					begin
						nxt_s.rx_mii.stb = 1'b1;
						nxt_s.rx_mii.d   = rx_dec[3:0];
						nxt_s.rx_mii.er  = ~rx_dec[4];
					end
				end
			end
			fetc_pkg::RX_ENDR:
			begin
				nxt_s.rx_cnt = s_ff.rx_cnt + 3'h1;
				if (s_ff.rx_cnt == fetc_pkg::GRP_LAST)
				begin
					nxt_s.rx_cnt = 3'h0;
					nxt_s.rx_st  = fetc_pkg::RX_HUNT;
				end
			end
			default:
			begin
				nxt_s.rx_st     = fetc_pkg::RX_HUNT;
				nxt_s.rx_mii.dv = 1'b0;
			end
		endcase
		if (!rx_go)
		begin
			nxt_s.rx_st      = fetc_pkg::RX_HUNT;
			nxt_s.rx_cnt     = 3'h0;
			nxt_s.rx_pre2    = 1'b0;
			nxt_s.rx_mii.dv  = 1'b0;
			nxt_s.rx_mii.er  = 1'b0;
			nxt_s.rx_mii.stb = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_ff         <= '0;
			s_ff.tx_st   <= fetc_pkg::TX_IDLE;
			s_ff.rx_st   <= fetc_pkg::RX_HUNT;
			s_ff.tx_lfsr <= fetc_pkg::LFSR_SEED;
			s_ff.rx_lfsr <= fetc_pkg::LFSR_SEED;
		end
		else
			s_ff <= nxt_s;
	end

	assign o_tx_stb  = s_ff.tx_stb;
	assign o_tx_line = s_ff.tx_line;
	assign o_rx_lock = s_ff.rx_lock;
	assign o_rx_mii  = s_ff.rx_mii;

	property p_idle_fill;
		@(posedge i_core_clk) disable iff (!rst_n)
		(tx_load && !i_tx_bypass && !i_tx_mii.en && s_ff.tx_st == fetc_pkg::TX_IDLE)
		|=> (s_ff.tx_st == fetc_pkg::TX_IDLE) && (s_ff.tx_sh == (fetc_pkg::CG_IDLE ^ $past(tx_key)));
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("idle not sent");

	property p_start_jk;
		@(posedge i_core_clk) disable iff (!rst_n)
		(tx_load && !i_tx_bypass && i_tx_mii.en && s_ff.tx_st == fetc_pkg::TX_IDLE)
		|=> (s_ff.tx_sh == (fetc_pkg::CG_J ^ $past(tx_key))) && o_tx_stb ##5 (s_ff.tx_st == fetc_pkg::TX_K);
	endproperty
	a_start_jk: assert property (p_start_jk) else $error("start pair wrong");

	property p_end_t;
		@(posedge i_core_clk) disable iff (!rst_n)
		(tx_load && !i_tx_bypass && !i_tx_mii.en && s_ff.tx_st == fetc_pkg::TX_DATA)
		|=> (s_ff.tx_st == fetc_pkg::TX_T) && !o_tx_stb && (s_ff.tx_sh == (fetc_pkg::CG_T ^ $past(tx_key)));
	endproperty
	a_end_t: assert property (p_end_t) else $error("end delimiter wrong");

	property p_enc_data;
		@(posedge i_core_clk) disable iff (!rst_n)
		(tx_load && !i_tx_bypass && i_tx_mii.en && s_ff.tx_st == fetc_pkg::TX_DATA)
		|=> s_ff.tx_sh == (fetc_pkg::CG_DATA[$past(i_tx_mii.d)] ^ $past(tx_key));
	endproperty
	a_enc_data: assert property (p_enc_data) else $error("data group wrong");

	property p_bypass;
		@(posedge i_core_clk) disable iff (!rst_n)
		(tx_load && i_tx_bypass) |=> s_ff.tx_sh == ($past(i_tx_sym) ^ $past(tx_key));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass symbol wrong");

	property p_serial;
		@(posedge i_core_clk) disable iff (!rst_n)
		!tx_load |=> s_ff.tx_sh == {$past(s_ff.tx_sh[3:0]), 1'b0};
	endproperty
	a_serial: assert property (p_serial) else $error("serialiser slipped");

	property p_nrzi;
		@(posedge i_core_clk) disable iff (!rst_n)
		s_ff.tx_sh[4] |=> s_ff.tx_nrzi != $past(s_ff.tx_nrzi);
	endproperty
	a_nrzi: assert property (p_nrzi) else $error("nrzi missed a one");

	property p_mlt_alt;
		@(posedge i_core_clk) disable iff (!rst_n)
		$rose(o_tx_line.pos) |-> !o_tx_line.neg && $past(s_ff.tx_ph) == 2'h0;
	endproperty
	a_mlt_alt: assert property (p_mlt_alt) else $error("line pulses not alternating");

	property p_rx_nrzi;
		@(posedge i_core_clk) disable iff (!rst_n)
		(i_rx_line != s_ff.rx_lvl) |=> s_ff.rx_nrzi != $past(s_ff.rx_nrzi);
	endproperty
	a_rx_nrzi: assert property (p_rx_nrzi) else $error("line change lost");

	property p_lock_drop;
		@(posedge i_core_clk) disable iff (!rst_n)
		!i_sig_det |=> !o_rx_lock ##1 !o_rx_mii.dv;
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock kept without signal");

	property p_pre_pair;
		@(posedge i_core_clk) disable iff (!rst_n)
		$rose(o_rx_mii.dv) |-> o_rx_mii.stb && o_rx_mii.d == fetc_pkg::PRE_NIB
		##1 (o_rx_mii.stb && o_rx_mii.d == fetc_pkg::PRE_NIB) || !o_rx_mii.dv;
	endproperty
	a_pre_pair: assert property (p_pre_pair) else $error("preamble nibbles wrong");

	property p_end_strip;
		@(posedge i_core_clk) disable iff (!rst_n)
		(s_ff.rx_st == fetc_pkg::RX_ENDR) |-> !o_rx_mii.dv && !o_rx_mii.stb;
	endproperty
	a_end_strip: assert property (p_end_strip) else $error("end pair passed on");

	// loss of signal legally cuts the held error short
	property p_err_hold;
		@(posedge i_core_clk) disable iff (!rst_n || !i_sig_det)
		(o_rx_mii.stb && o_rx_mii.er && rx_go) |=> o_rx_mii.er [*4];
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error not held a nibble time");

	c_tx_frame: cover property (@(posedge i_core_clk) disable iff (!rst_n) s_ff.tx_st == fetc_pkg::TX_R);
	c_rx_frame: cover property (@(posedge i_core_clk) disable iff (!rst_n) $fell(o_rx_mii.dv));
	c_rx_err: cover property (@(posedge i_core_clk) disable iff (!rst_n) o_rx_mii.stb && o_rx_mii.er);
	c_bypass: cover property (@(posedge i_core_clk) disable iff (!rst_n) tx_load && i_tx_bypass);
endmodule : fetc_top
`default_nettype wire
